// File: design/accumulator_modify_pkg.sv
package accumulator_modify_pkg;

  localparam int ACC_W = 36;
  localparam int PTR_W = 16;
  localparam int NACC  = 4;
  localparam int NPTR  = 6;

  // Register byte offsets
  localparam logic [7:0] OFS_ACC     = 8'h00;
  localparam logic [7:0] OFS_PROD    = 8'h20;
  localparam logic [7:0] OFS_STATUS  = 8'h24;
  localparam logic [7:0] OFS_MODEN   = 8'h28;
  localparam logic [7:0] OFS_MODLAST = 8'h2C;
  localparam logic [7:0] OFS_STEP    = 8'h30;
  localparam logic [7:0] OFS_CMD     = 8'h34;
  localparam logic [7:0] OFS_PTR     = 8'h40;
  localparam logic [7:0] OFS_PTR_END = 8'h54;

  // Register select codes: word index of the offset
  localparam logic [4:0] SEL_PROD    = 5'h08;
  localparam logic [4:0] SEL_STATUS  = 5'h09;
  localparam logic [4:0] SEL_MODEN   = 5'h0A;
  localparam logic [4:0] SEL_MODLAST = 5'h0B;
  localparam logic [4:0] SEL_STEP    = 5'h0C;
  localparam logic [4:0] SEL_CMD     = 5'h0D;
  localparam logic [4:0] SEL_PTR     = 5'h10;
  localparam logic [4:0] SEL_NONE    = 5'h1F;

  // Status word one layout
  localparam int FZ = 0;
  localparam int FM = 1;
  localparam int FN = 2;
  localparam int FV = 3;
  localparam int FC = 4;
  localparam int FE = 5;
  localparam int FL = 6;
  localparam int FR = 7;
  localparam int ST_SHIFT_KIND = 8;
  localparam int ST_PS_LSB     = 9;
  localparam int ST_ERR        = 15;

  // Command word layout
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_ACC      = 2;
  localparam int CMD_COND     = 3;
  localparam int CMD_FUNC_LSB = 4;
  localparam int CMD_PTR_LSB  = 8;
  localparam int CMD_PM_LSB   = 11;
  localparam int CMD_BYPASS   = 13;
  localparam int CMD_SRC_LSB  = 16;
  localparam int CMD_DST_LSB  = 20;
  localparam logic [2:0] MOV_ACC_CODE = 3'h6;

  localparam logic [ACC_W-1:0] RND_CONST   = 36'h0_0000_8000;
  localparam logic [ACC_W-1:0] ACC_MIN     = 36'h8_0000_0000;
  localparam logic [ACC_W-1:0] ACC_RST     = 36'h0_0000_0000;
  localparam logic [PTR_W-1:0] PTR_RST     = 16'h0000;
  localparam logic [PTR_W-1:0] MODLAST_RST = 16'h00FF;
  localparam logic [PTR_W-1:0] STEP_RST    = 16'h0001;
  localparam logic [7:0]       FLAGS_RST   = 8'h00;
  localparam logic [1:0]       AXI_OKAY    = 2'h0;
  localparam logic [1:0]       AXI_SLVERR  = 2'h2;

  typedef enum logic [1:0] {OP_MODA, OP_MODB, OP_MODR, OP_MOV} op_t;
  typedef enum logic [3:0] {
    SHIFT_RIGHT_ONE, SHIFT_LEFT_ONE, RIGHT_SHIFT_FOUR, LEFT_SHIFT_FOUR,
    ROT_RIGHT, ROT_LEFT, F_CLR, F_COPY, F_NEG, F_NOT, F_RND, F_PACR,
    F_CLRR, F_INC, F_DEC
  } func_t;
  typedef enum logic [1:0] {PM_NONE, PM_INC, PM_DEC, PM_STEP} ptrmode_t;

endpackage : accumulator_modify_pkg

// File: design/ptr_mod_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ptr_mod_if;
  import accumulator_modify_pkg::*;
  logic [PTR_W-1:0] ptrIn;
  logic [PTR_W-1:0] step;
  logic [PTR_W-1:0] modLast;
  logic             modOn;
  ptrmode_t         mode;
  logic [PTR_W-1:0] ptrOut;
  logic             zero;
  modport core (output ptrIn, step, modLast, modOn, mode, input ptrOut, zero);
  modport unit (input ptrIn, step, modLast, modOn, mode, output ptrOut, zero);
endinterface : ptr_mod_if
`default_nettype wire

// File: design/pointer_modify_unit.sv
`timescale 1ns/10ps
`default_nettype none
module pointer_modify_unit
  import accumulator_modify_pkg::*;
(
  // Pointer request and result
  ptr_mod_if.unit pm
);
  logic [PTR_W-1:0] sum;
  logic [PTR_W-1:0] negStep;

  always_comb begin
    sum     = pm.ptrIn + pm.step;
    negStep = PTR_W'(16'h0000 - pm.step);
    unique case (pm.mode)
      PM_NONE: pm.ptrOut = pm.ptrIn;
      PM_INC: begin
        if (pm.modOn && pm.ptrIn == pm.modLast) pm.ptrOut = PTR_RST;
        else pm.ptrOut = pm.ptrIn + 16'h0001;
      end
      PM_DEC: begin
        if (pm.modOn && pm.ptrIn == PTR_RST) pm.ptrOut = pm.modLast;
        else pm.ptrOut = pm.ptrIn - 16'h0001;
      end
      PM_STEP: begin
        // Window is 0..modLast; a step leaving it wraps by the window size
        if (pm.modOn && !pm.step[PTR_W-1] && sum > pm.modLast) begin
          pm.ptrOut = sum - pm.modLast - 16'h0001;
        end else if (pm.modOn && pm.step[PTR_W-1] && pm.ptrIn < negStep) begin
          pm.ptrOut = sum + pm.modLast + 16'h0001;
        end else begin
          pm.ptrOut = sum;
        end
      end
    endcase
    pm.zero = (pm.ptrOut == PTR_RST);
  end

endmodule : pointer_modify_unit
`default_nettype wire

// File: design/accumulator_modify_unit.sv
// Overview of operation
// - False condition leaves accumulator and flags unchanged.
// - Shift kind bit selects arithmetic or logical.
// - Carry takes the last bit shifted out.
// - Arithmetic left shift overflow when operand does not fit.
// - Rotate right through carry, carry gets bit 0.
// - Rotate left through carry, carry gets bit 35.
// - Rounding adds or loads 0x8000.
// - Product sign-extended then shifted by field.
// - B accumulator: shifts, rotates and clear only.
// - Pointer post-modify honours its modulo enable.
// - Bypass option forces linear pointer modify.
// - Pointer modify sets only zero-register flag.
// - Transfer copies source; only permitted pairings.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module accumulator_modify_unit
  import accumulator_modify_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  function automatic logic [4:0] regSel(input logic [7:0] a);
    if (a[1:0] != 2'h0) return SEL_NONE;
    if (a <= OFS_CMD || (a >= OFS_PTR && a <= OFS_PTR_END)) return a[6:2];
    return SEL_NONE;
  endfunction : regSel

  function automatic logic [7:0] withZmne(input logic [7:0] f, input logic [ACC_W-1:0] r);
    logic [7:0] o;
    logic       ext;
    o      = f;
    ext    = !((&r[35:31]) || !(|r[35:31]));
    o[FZ]  = (r == ACC_RST);
    o[FM]  = r[ACC_W-1];
    o[FE]  = ext;
    o[FN]  = !ext && (r[31] ^ r[30]);
    return o;
  endfunction : withZmne

  // Returns {overflow, carry, sum}
  function automatic logic [ACC_W+1:0] add36(input logic [ACC_W-1:0] a, input logic [ACC_W-1:0] b);
    logic [ACC_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return {(a[35] == b[35]) && (s[35] != a[35]), s};
  endfunction : add36

  logic [ACC_W-1:0] acc [NACC];
  logic [PTR_W-1:0] ptr [NPTR];
  logic [31:0]      prod;
  logic [7:0]       flags;
  logic             shiftLogical;
  logic [1:0]       prodShift;
  logic             err;
  logic [NPTR-1:0]  modEn;
  logic [PTR_W-1:0] modLast;
  logic [PTR_W-1:0] step;

  logic             awHeld;
  logic             wHeld;
  logic [7:0]       awAddr;
  logic [31:0]      wData;
  logic [3:0]       wStrb;
  logic             doWrite;
  logic [4:0]       wrSel;
  logic [31:0]      wrOld;
  logic [31:0]      wrVal;
  logic [31:0]      strbMask;

  logic             exec;
  op_t              op;
  logic [1:0]       accIdx;
  logic [ACC_W-1:0] opnd;
  logic [ACC_W-1:0] pExt;
  logic [ACC_W-1:0] pShift;
  logic [ACC_W+1:0] addRes;
  logic [ACC_W-1:0] next_acc;
  logic [7:0]       next_flags;
  logic             vUpd;
  logic             modLegal;
  logic [2:0]       ptrIdx;
  logic [2:0]       srcCode;
  logic [2:0]       dstCode;
  logic [PTR_W-1:0] movVal;
  logic             movLegal;
  logic             cmdBad;

  ptr_mod_if pm ();

  pointer_modify_unit u_ptr (
    .pm (pm.unit)
  );

  // Register value as software reads it
  function automatic logic [31:0] regValue(input logic [4:0] s);
    if (s < SEL_PROD) return s[0] ? {28'h0, acc[s[2:1]][35:32]} : acc[s[2:1]][31:0];
    if (s >= SEL_PTR && s < SEL_PTR + 5'(NPTR)) return {16'h0, ptr[s[2:0]]};
    unique case (s)
      SEL_PROD:    return prod;
      SEL_STATUS:  return {16'h0, err, 4'h0, prodShift, shiftLogical, flags};
      SEL_MODEN:   return {26'h0, modEn};
      SEL_MODLAST: return {16'h0, modLast};
      SEL_STEP:    return {16'h0, step};
      default:     return 32'h0;
    endcase
  endfunction : regValue

  // Write channel: address and data are taken in either order
  assign s_axi_awready = !awHeld;
  assign s_axi_wready  = !wHeld;
  assign doWrite       = awHeld && wHeld && !s_axi_bvalid;
  assign wrSel         = regSel(awAddr);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddr       <= 8'h00;
      wData        <= 32'h0;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wrSel == SEL_NONE) ? AXI_SLVERR : AXI_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= regValue(regSel(s_axi_araddr));
      s_axi_rresp  <= (regSel(s_axi_araddr) == SEL_NONE) ? AXI_SLVERR : AXI_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_strb
      assign strbMask[gb*8 +: 8] = {8{wStrb[gb]}};
    end
  endgenerate

  assign wrOld = regValue(wrSel);
  assign wrVal = (wData & strbMask) | (wrOld & ~strbMask);

  // Command decode; the command executes at the edge that answers its write
  assign op      = op_t'(wrVal[CMD_OP_LSB +: 2]);
  assign exec    = doWrite && wrSel == SEL_CMD && wrVal[CMD_COND];
  assign accIdx  = {op == OP_MODB, wrVal[CMD_ACC]};
  assign opnd    = acc[accIdx];
  assign ptrIdx  = wrVal[CMD_PTR_LSB +: 3];
  assign srcCode = wrVal[CMD_SRC_LSB +: 3];
  assign dstCode = wrVal[CMD_DST_LSB +: 3];
  assign pExt    = {{4{prod[31]}}, prod};

  always_comb begin
    unique case (prodShift)
      2'h0: pShift = pExt;
      2'h1: pShift = {pExt[35], pExt[35:1]};
      2'h2: pShift = {pExt[34:0], 1'b0};
      2'h3: pShift = {pExt[33:0], 2'b00};
    endcase
  end

  assign pm.ptrIn   = ptr[(ptrIdx < 3'(NPTR)) ? ptrIdx : 3'h0];
  assign pm.mode    = ptrmode_t'(wrVal[CMD_PM_LSB +: 2]);
  assign pm.step    = step;
  assign pm.modLast = modLast;
  assign pm.modOn   = modEn[(ptrIdx < 3'(NPTR)) ? ptrIdx : 3'h0] && !wrVal[CMD_BYPASS];

  // Accumulator modify datapath
  always_comb begin
    next_acc   = opnd;
    next_flags = flags;
    vUpd       = 1'b0;
    modLegal   = 1'b1;
    addRes     = add36(opnd, RND_CONST);
    if (op == OP_MODB && wrVal[CMD_FUNC_LSB +: 4] > 4'(F_CLR)) modLegal = 1'b0;
    unique case (func_t'(wrVal[CMD_FUNC_LSB +: 4]))
      SHIFT_RIGHT_ONE: begin
        next_acc       = {shiftLogical ? 1'b0 : opnd[35], opnd[35:1]};
        next_flags[FC] = opnd[0];
        if (!shiftLogical) next_flags[FV] = 1'b0;
      end
      SHIFT_LEFT_ONE: begin
        next_acc       = {opnd[34:0], 1'b0};
        next_flags[FC] = opnd[35];
        if (!shiftLogical) next_flags[FV] = opnd[35] != opnd[34];
        vUpd           = !shiftLogical;
      end
      RIGHT_SHIFT_FOUR: begin
        next_acc       = {shiftLogical ? 4'h0 : {4{opnd[35]}}, opnd[35:4]};
        next_flags[FC] = opnd[3];
        if (!shiftLogical) next_flags[FV] = 1'b0;
      end
      LEFT_SHIFT_FOUR: begin
        next_acc       = {opnd[31:0], 4'h0};
        next_flags[FC] = opnd[32];
        if (!shiftLogical) next_flags[FV] = !((&opnd[35:31]) || !(|opnd[35:31]));
        vUpd           = !shiftLogical;
      end
      ROT_RIGHT: begin
        next_acc       = {flags[FC], opnd[35:1]};
        next_flags[FC] = opnd[0];
      end
      ROT_LEFT: begin
        next_acc       = {opnd[34:0], flags[FC]};
        next_flags[FC] = opnd[35];
      end
      F_CLR:  next_acc = ACC_RST;
      F_COPY: next_acc = opnd;
      F_NOT:  next_acc = ~opnd;
      F_CLRR: next_acc = RND_CONST;
      F_NEG: begin
        next_acc       = ACC_RST - opnd;
        next_flags[FC] = opnd != ACC_RST;
        next_flags[FV] = opnd == ACC_MIN;
        vUpd           = 1'b1;
      end
      F_RND, F_PACR, F_INC, F_DEC: begin
        unique case (func_t'(wrVal[CMD_FUNC_LSB +: 4]))
          F_PACR:  addRes = add36(pShift, RND_CONST);
          F_INC:   addRes = add36(opnd, 36'h0_0000_0001);
          F_DEC:   addRes = add36(opnd, 36'hF_FFFF_FFFF);
          default: addRes = add36(opnd, RND_CONST);
        endcase
        next_acc       = addRes[ACC_W-1:0];
        next_flags[FC] = addRes[ACC_W];
        next_flags[FV] = addRes[ACC_W+1];
        vUpd           = 1'b1;
      end
      default: modLegal = 1'b0;
    endcase
    // Limit latches any overflow; logical shifts and rotates keep V and L
    next_flags[FL] = flags[FL] | (vUpd & next_flags[FV]);
    next_flags     = withZmne(next_flags, next_acc);
  end

  // Transfer source and permitted pairings
  always_comb begin
    movVal   = (srcCode == MOV_ACC_CODE) ? acc[{1'b0, wrVal[CMD_ACC]}][PTR_W-1:0] : ptr[(srcCode < 3'(NPTR)) ? srcCode : 3'h0];
    movLegal = (srcCode < 3'(NPTR) || srcCode == MOV_ACC_CODE)
            && (dstCode < 3'(NPTR) || dstCode == MOV_ACC_CODE)
            && srcCode != dstCode;
  end

  always_comb begin
    unique case (op)
      OP_MODA, OP_MODB: cmdBad = !modLegal;
      OP_MODR:          cmdBad = ptrIdx >= 3'(NPTR);
      OP_MOV:           cmdBad = !movLegal;
    endcase
  end

  // Accumulators and product
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NACC; i++) acc[i] <= ACC_RST;
      prod <= 32'h0;
    end else if (exec && !cmdBad && (op == OP_MODA || op == OP_MODB)) begin
      acc[accIdx] <= next_acc;
    end else if (exec && !cmdBad && op == OP_MOV && dstCode == MOV_ACC_CODE) begin
      acc[{1'b0, wrVal[CMD_ACC]}] <= {{20{movVal[PTR_W-1]}}, movVal};
    end else if (doWrite && wrSel < SEL_PROD) begin
      if (wrSel[0]) acc[wrSel[2:1]][35:32] <= wrVal[3:0];
      else acc[wrSel[2:1]][31:0] <= wrVal;
    end else if (doWrite && wrSel == SEL_PROD) begin
      prod <= wrVal;
    end
  end

  // Address pointers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NPTR; i++) ptr[i] <= PTR_RST;
    end else if (exec && !cmdBad && op == OP_MODR) begin
      ptr[ptrIdx] <= pm.ptrOut;
    end else if (exec && !cmdBad && op == OP_MOV && dstCode != MOV_ACC_CODE) begin
      ptr[dstCode] <= movVal;
    end else if (doWrite && wrSel >= SEL_PTR && wrSel < SEL_PTR + 5'(NPTR)) begin
      ptr[wrSel[2:0]] <= wrVal[PTR_W-1:0];
    end
  end

  // Status word one; the refusal flag is write-one-to-clear and a new refusal wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags        <= FLAGS_RST;
      shiftLogical <= 1'b0;
      prodShift    <= 2'h0;
      err          <= 1'b0;
    end else begin
      if (exec && !cmdBad && (op == OP_MODA || op == OP_MODB)) begin
        flags <= next_flags;
      end else if (exec && !cmdBad && op == OP_MODR) begin
        flags[FR] <= pm.zero;
      end else if (exec && !cmdBad && op == OP_MOV && dstCode == MOV_ACC_CODE) begin
        flags <= withZmne(flags, {{20{movVal[PTR_W-1]}}, movVal});
      end else if (doWrite && wrSel == SEL_STATUS) begin
        flags        <= wrVal[7:0];
        shiftLogical <= wrVal[ST_SHIFT_KIND];
        prodShift    <= wrVal[ST_PS_LSB +: 2];
      end
      if (exec && cmdBad) err <= 1'b1;
      else if (doWrite && wrSel == SEL_STATUS && wrVal[ST_ERR]) err <= 1'b0;
    end
  end

  // Modulo configuration
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      modEn   <= '0;
      modLast <= MODLAST_RST;
      step    <= STEP_RST;
    end else if (doWrite) begin
      if (wrSel == SEL_MODEN) modEn <= wrVal[NPTR-1:0];
      if (wrSel == SEL_MODLAST) modLast <= wrVal[PTR_W-1:0];
      if (wrSel == SEL_STEP) step <= wrVal[PTR_W-1:0];
    end
  end

  logic  isMod;
  func_t fnNow;
  assign isMod = exec && !cmdBad && (op == OP_MODA || op == OP_MODB);
  assign fnNow = func_t'(wrVal[CMD_FUNC_LSB +: 4]);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_cond_false_hold: assert property (doWrite && wrSel == SEL_CMD && !wrVal[CMD_COND]
    |=> $stable(flags) && $stable(acc[$past(accIdx)])) else $error("acc or flags changed");
  chk_logic_shift_vl: assert property (isMod && shiftLogical && fnNow <= LEFT_SHIFT_FOUR
    |=> flags[FV] == $past(flags[FV]) && flags[FL] == $past(flags[FL])) else $error("V or L moved");
  chk_shr_carry: assert property (isMod && fnNow == RIGHT_SHIFT_FOUR
    |=> flags[FC] == $past(opnd[3])) else $error("shift carry wrong");
  chk_shl_overflow: assert property (isMod && !shiftLogical && fnNow == SHIFT_LEFT_ONE
    |=> flags[FV] == ($past(opnd[35]) != $past(opnd[34]))) else $error("shift overflow wrong");
  chk_ror_carry: assert property (isMod && fnNow == ROT_RIGHT
    |=> flags[FC] == $past(opnd[0]) && acc[$past(accIdx)][35] == $past(flags[FC])) else $error("rotate wrong");
  chk_rnd_value: assert property (isMod && fnNow == F_RND
    |=> acc[$past(accIdx)] == $past(opnd) + RND_CONST) else $error("round wrong");
  chk_modr_flags: assert property (exec && !cmdBad && op == OP_MODR
    |=> flags[6:0] == $past(flags[6:0]) && flags[FR] == (ptr[$past(ptrIdx)] == PTR_RST)) else $error("modr flags");
  chk_single_cycle: assert property (doWrite |=> s_axi_bvalid && !awHeld && !wHeld) else $error("late answer");
  chk_clr_carry: assert property (isMod && fnNow == F_CLR
    |=> acc[$past(accIdx)] == ACC_RST && flags[FC] == $past(flags[FC]) && flags[FZ]) else $error("clear flags");

  cov_pacr: cover property (isMod && fnNow == F_PACR && prodShift != 2'h0);
  cov_modulo_wrap: cover property (exec && op == OP_MODR && pm.modOn && pm.ptrOut == PTR_RST);
  cov_refused: cover property (exec && cmdBad ##1 err);

endmodule : accumulator_modify_unit
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import accumulator_modify_pkg::*;
  logic        mclk, rst;
  logic [7:0]  awA, arA;
  logic [31:0] wD, rdata;
  logic [3:0]  wS;
  logic        awV, wV, bRdy, arV, rRdy;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          failures, tests_run, i;
  logic [31:0] d;
  logic [1:0]  r;
  // Function table: operand low word, expected low, high and status
  logic [3:0]  tf [8] = '{F_CLR, F_COPY, F_NOT, F_CLRR, F_NEG, F_RND, F_INC, F_DEC};
  logic [31:0] ti [8] = '{32'h5, 32'h4000_0000, 32'hFFFF_FFFF, 32'h0, 32'h1, 32'h7FFF, 32'hFFFF_FFFF, 32'h0};
  logic [31:0] tl [8] = '{32'h0, 32'h4000_0000, 32'h0, 32'h8000, 32'hFFFF_FFFF, 32'hFFFF, 32'h0, 32'hFFFF_FFFF};
  logic [31:0] th [8] = '{32'h0, 32'h0, 32'hF, 32'h0, 32'hF, 32'h0, 32'h1, 32'hF};
  logic [31:0] ts [8] = '{32'h19, 32'h1C, 32'h3A, 32'h18, 32'h12, 32'h0, 32'h20, 32'h2};

  accumulator_modify_unit accumulator_modify_unit_i (
    .mclk(mclk), .rst(rst),
    .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awready),
    .s_axi_wdata(wD), .s_axi_wstrb(wS), .s_axi_wvalid(wV), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bRdy),
    .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rRdy)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic complete_run();
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    int   n;
    n = 0;
    @(posedge mclk);
    awA <= a; wD <= v; awV <= 1'b1; wV <= 1'b1; bRdy <= 1'b1;
    do begin
      @(negedge mclk);
      ta = awV && awready;
      tw = wV && wready;
      tb = bvalid;
      n++;
      @(posedge mclk);
      if (ta) awV <= 1'b0;
      if (tw) wV <= 1'b0;
      if (tb === 1'b1) bRdy <= 1'b0;
    end while (tb !== 1'b1 && n < 200);
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, tr;
    int   n;
    n = 0;
    @(posedge mclk);
    arA <= a; arV <= 1'b1; rRdy <= 1'b1;
    do begin
      @(negedge mclk);
      ta = arV && arready;
      tr = rvalid;
      v = rdata;
      rs = rresp;
      n++;
      @(posedge mclk);
      if (ta) arV <= 1'b0;
      if (tr === 1'b1) rRdy <= 1'b0;
    end while (tr !== 1'b1 && n < 200);
  endtask : axr

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0]  rs;
    axr(a, v, rs);
    chk(v, exp);
  endtask : rc

  // Accumulator modify command: condition bit set unless cond is low
  task automatic mc(input logic [1:0] op, input logic acc, input logic [3:0] f, input logic cond);
    axw(OFS_CMD, {24'h0, f, cond, acc, op});
  endtask : mc

  initial begin
    #200000;
    failures++;
    complete_run();
  end

  initial begin
    rst = 1'b1; awA = 8'h00; arA = 8'h00; wD = 32'h0; wS = 4'hF;
    awV = 1'b0; wV = 1'b0; bRdy = 1'b0; arV = 1'b0; rRdy = 1'b0;
    failures = 0; tests_run = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rc(OFS_STATUS, 32'h0);
    rc(OFS_MODLAST, 32'hFF);
    rc(OFS_STEP, 32'h1);
    axr(8'h38, d, r);
    chk({30'h0, r}, {30'h0, AXI_SLVERR});
    $display("test reset and map done");
    axw(OFS_ACC, 32'h3);
    mc(OP_MODA, 1'b0, SHIFT_LEFT_ONE, 1'b0);
    rc(OFS_ACC, 32'h3);
    rc(OFS_STATUS, 32'h0);
    mc(OP_MODA, 1'b0, SHIFT_RIGHT_ONE, 1'b1);
    rc(OFS_ACC, 32'h1);
    rc(OFS_STATUS, 32'h10);
    axw(8'h08, 32'h0);
    axw(8'h0C, 32'h1);
    mc(OP_MODA, 1'b1, LEFT_SHIFT_FOUR, 1'b1);
    rc(8'h0C, 32'h0);
    rc(OFS_STATUS, 32'h59);
    axw(OFS_STATUS, 32'h108);
    axw(OFS_ACC, 32'h0);
    axw(8'h04, 32'h8);
    mc(OP_MODA, 1'b0, SHIFT_LEFT_ONE, 1'b1);
    rc(OFS_STATUS, 32'h119);
    $display("test shifts done");
    axw(OFS_STATUS, 32'h8);
    axw(OFS_ACC, 32'h1);
    mc(OP_MODA, 1'b0, ROT_RIGHT, 1'b1);
    rc(OFS_ACC, 32'h0);
    rc(OFS_STATUS, 32'h19);
    mc(OP_MODA, 1'b0, ROT_LEFT, 1'b1);
    rc(OFS_ACC, 32'h1);
    rc(OFS_STATUS, 32'h8);
    $display("test rotates done");
    for (i = 0; i < 8; i++) begin
      axw(OFS_STATUS, 32'h18);
      axw(OFS_ACC, ti[i]);
      axw(8'h04, 32'h0);
      mc(OP_MODA, 1'b0, tf[i], 1'b1);
      rc(OFS_ACC, tl[i]);
      rc(8'h04, th[i]);
      rc(OFS_STATUS, ts[i]);
    end
    $display("test function table done");
    axw(OFS_PROD, 32'hFFFF_0000);
    axw(OFS_STATUS, 32'h400);
    mc(OP_MODA, 1'b0, F_PACR, 1'b1);
    rc(OFS_ACC, 32'hFFFE_8000);
    rc(8'h04, 32'hF);
    rc(OFS_STATUS, 32'h402);
    $display("test product rounding done");
    axw(OFS_STATUS, 32'h0);
    axw(8'h10, 32'h5);
    mc(OP_MODB, 1'b0, F_COPY, 1'b1);
    rc(OFS_STATUS, 32'h8000);
    rc(8'h10, 32'h5);
    mc(OP_MODB, 1'b0, SHIFT_RIGHT_ONE, 1'b1);
    rc(8'h10, 32'h2);
    rc(OFS_STATUS, 32'h8010);
    axw(OFS_STATUS, 32'h8000);
    rc(OFS_STATUS, 32'h0);
    $display("test b accumulator done");
    axw(OFS_STATUS, 32'h19);
    axw(OFS_MODEN, 32'h1);
    axw(OFS_PTR, 32'hFF);
    axw(OFS_CMD, 32'h080A);
    rc(OFS_PTR, 32'h0);
    rc(OFS_STATUS, 32'h99);
    axw(OFS_PTR, 32'hFF);
    axw(OFS_CMD, 32'h280A);
    rc(OFS_PTR, 32'h100);
    rc(OFS_STATUS, 32'h19);
    axw(OFS_PTR, 32'h0);
    axw(OFS_CMD, 32'h100A);
    rc(OFS_PTR, 32'hFF);
    $display("test pointer modify done");
    axw(OFS_CMD, 32'h0020_000B);
    rc(8'h48, 32'hFF);
    axw(OFS_CMD, 32'h0036_000B);
    rc(8'h4C, 32'h8000);
    axw(OFS_CMD, 32'h0022_000B);
    rc(OFS_STATUS, 32'h8019);
    $display("test transfer done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
